// *** core/oer_core.sv ***
// Added by the designer: the AXI4-Lite slave port and the register addresses.
`timescale 1ns/1ns
// Notes on behaviour
// - mode 00: bytes pass unchecked, full 4 kB code space.
// - mode 0F: one parity byte per code byte, 4 kB plus 4 kB.
// - mode 0F: each fetched byte checked and corrected before delivery.
// - mode F0: four identical copies, code limited to 2 kB.
// - mode F0: read all four banks, deliver bitwise AND.
// - never-programmed bits read as one.
// - unlock bits clear: block readout of OTP and executing SRAM.
// - lock acts only after stored in OTP and a later power-on reset or compare-mismatch restart.
// - after power-on reset, configuration loads from OTP, then firmware too if SRAM is selected.
// - code runs from SRAM copy or straight from OTP, by select bit.
// - compare mismatch: internal reset, recopy, restart execution.
module oer_core import oer_pkg::*; (
  input  wire logic            aclk,
  input  wire logic            aresetn,
  input  wire oer_axi_req_type axi_req,
  output oer_axi_rsp_type      axi_rsp,
  input  wire logic            fetch_req,
  input  wire logic [11:0]     fetch_addr,
  output logic                 fetch_valid,
  output logic [7:0]           fetch_data,
  output logic                 otp_ren,
  output logic [12:0]          otp_addr,
  input  wire logic [7:0]      otp_rdata,
  output logic                 core_restart,
  output logic                 boot_done
);
  // ************************************************************
  // state
  // ************************************************************
  typedef struct packed {
    oer_state_type   state;
    oer_purpose_type purpose;
    logic [1:0]      bank;
    logic [11:0]     eaddr;
    logic [11:0]     walk;
    logic [7:0]      acc;
    logic [7:0]      ecc_mode;
    logic [1:0]      readout_unlock_bits;
    logic            code_src;
    logic            sram_otp_compare_enable;
    logic            readout_guard;
    logic            boot_done;
    logic [11:0]     mem_addr;
    logic [7:0]      mem_data;
    logic            host_pend;
    logic            aw_hold;
    logic            w_hold;
    logic [AW-1:0]   awaddr;
    logic [31:0]     wdata;
    logic            wbyte;
    logic            fetch_valid;
    logic [7:0]      fetch_data;
    logic            otp_ren;
    logic [12:0]     otp_addr;
    logic            core_restart;
    oer_axi_rsp_type axi;
  } oer_regs_type;

  localparam oer_regs_type RESET_VAL = '{state: ST_ISSUE, purpose: P_CFG,
    eaddr: CFG_BASE, fetch_data: BLANK, default: '0};

  oer_regs_type st;
  oer_regs_type next_st;
  logic [7:0]   sram [4096];
  logic         sram_we;
  logic [11:0]  sram_wa;
  logic [7:0]   sram_wd;
  logic [7:0]   mode_eff;
  logic         last_bank;
  logic [7:0]   rbyte;
  logic [11:0]  last_addr;
  logic         mismatch;
  logic         host_set;

  assign axi_rsp      = st.axi;
  assign fetch_valid  = st.fetch_valid;
  assign fetch_data   = st.fetch_data;
  assign otp_ren      = st.otp_ren;
  assign otp_addr     = st.otp_addr;
  assign core_restart = st.core_restart;
  assign boot_done    = st.boot_done;

  // ************************************************************
  // next state
  // ************************************************************
  always_comb begin
    next_st = st;
    next_st.fetch_valid = 1'b0;
    next_st.otp_ren = 1'b0;
    next_st.core_restart = 1'b0;
    sram_we = 1'b0;
    sram_wa = st.walk;
    sram_wd = 8'h00;
    mismatch = 1'b0;
    host_set = 1'b0;
    // configuration bytes are stored raw whatever the code mode
    mode_eff = (st.purpose == P_CFG) ? MODE_NONE : st.ecc_mode;
    last_addr = (st.ecc_mode == MODE_QUAD) ? LAST_QUAD : LAST_FULL;
    case (mode_eff)
      MODE_PAR:  last_bank = (st.bank == 2'd1);
      MODE_QUAD: last_bank = (st.bank == 2'd3);
      default:   last_bank = 1'b1;
    endcase
    case (mode_eff)
      MODE_PAR:  rbyte = oer_fix(st.acc, otp_rdata);
      MODE_QUAD: rbyte = st.acc & otp_rdata;
      default:   rbyte = otp_rdata;
    endcase

    // axi write: address and data in either order
    if (axi_req.awvalid && st.axi.awready) begin
      next_st.aw_hold = 1'b1;
      next_st.awaddr = axi_req.awaddr;
      next_st.axi.awready = 1'b0;
    end
    if (axi_req.wvalid && st.axi.wready) begin
      next_st.w_hold = 1'b1;
      next_st.wdata = axi_req.wdata;
      next_st.wbyte = axi_req.wstrb[0];
      next_st.axi.wready = 1'b0;
    end
    if (st.aw_hold && st.w_hold && !st.axi.bvalid) begin
      next_st.axi.bvalid = 1'b1;
      next_st.axi.bresp = RESP_OK;
      case (st.awaddr)
        A_CFG0: if (st.wbyte) begin
          next_st.code_src = st.wdata[B_SRC];
          next_st.sram_otp_compare_enable = st.wdata[B_CMP];
        end
        A_CFG1: if (st.wbyte) next_st.ecc_mode = st.wdata[7:0];
        // the guard itself waits for the next power-on reset or compare-mismatch restart
        A_CFG2: if (st.wbyte) next_st.readout_unlock_bits = st.wdata[1:0];
        A_MADDR: begin
          next_st.mem_addr = st.wdata[11:0];
          host_set = !st.readout_guard;
          next_st.host_pend = host_set;
        end
        A_STATUS, A_MDATA: ;
        default: next_st.axi.bresp = RESP_ERR;
      endcase
    end
    if (st.axi.bvalid && axi_req.bready) begin
      next_st.axi.bvalid = 1'b0;
      next_st.aw_hold = 1'b0;
      next_st.w_hold = 1'b0;
      next_st.axi.awready = 1'b1;
      next_st.axi.wready = 1'b1;
    end
    if (!st.aw_hold && !st.axi.awready) next_st.axi.awready = 1'b1;
    if (!st.w_hold && !st.axi.wready) next_st.axi.wready = 1'b1;

    // axi read
    next_st.axi.arready = !st.axi.rvalid && !(axi_req.arvalid && st.axi.arready);
    if (axi_req.arvalid && st.axi.arready) begin
      next_st.axi.rvalid = 1'b1;
      next_st.axi.rresp = RESP_OK;
      next_st.axi.rdata = 32'h0;
      case (axi_req.araddr)
        A_CFG0: next_st.axi.rdata = {30'h0, st.sram_otp_compare_enable, st.code_src};
        A_CFG1: next_st.axi.rdata = {24'h0, st.ecc_mode};
        A_CFG2: next_st.axi.rdata = {30'h0, st.readout_unlock_bits};
        A_STATUS: next_st.axi.rdata = {29'h0, st.host_pend, st.readout_guard, st.boot_done};
        A_MADDR: next_st.axi.rdata = {20'h0, st.mem_addr};
        A_MDATA: begin
          if (st.readout_guard) next_st.axi.rresp = RESP_ERR;
          else next_st.axi.rdata = {24'h0, st.mem_data};
        end
        default: next_st.axi.rresp = RESP_ERR;
      endcase
    end else if (st.axi.rvalid && axi_req.rready) begin
      next_st.axi.rvalid = 1'b0;
    end

    // ************************************************************
    // read engine
    // ************************************************************
    case (st.state)
      ST_IDLE: begin
        next_st.bank = 2'd0;
        if (fetch_req && !st.fetch_valid) begin
          if (st.code_src) begin
            next_st.fetch_data = sram[fetch_addr];
            next_st.fetch_valid = 1'b1;
          end else begin
            next_st.purpose = P_FETCH;
            next_st.eaddr = fetch_addr;
            next_st.state = ST_ISSUE;
          end
        end else if (st.host_pend && st.code_src) begin
          next_st.mem_data = sram[st.mem_addr];
          // an address written in this very cycle keeps its request
          next_st.host_pend = host_set;
        end else if (st.host_pend) begin
          next_st.purpose = P_HOST;
          next_st.eaddr = st.mem_addr;
          next_st.state = ST_ISSUE;
        end else if (st.code_src && st.sram_otp_compare_enable) begin
          // compare only in slots the core leaves free
          next_st.purpose = P_CMP;
          next_st.eaddr = st.walk;
          next_st.state = ST_ISSUE;
        end
      end
      ST_ISSUE: begin
        next_st.otp_ren = 1'b1;
        case (mode_eff)
          MODE_PAR:  next_st.otp_addr = {st.bank[0], st.eaddr};
          MODE_QUAD: next_st.otp_addr = {st.bank, st.eaddr[10:0]};
          default:   next_st.otp_addr = {1'b0, st.eaddr};
        endcase
        next_st.state = ST_WAIT;
      end
      ST_WAIT: begin
        if (!last_bank) begin
          next_st.acc = (st.bank == 2'd0) ? otp_rdata : (st.acc & otp_rdata);
          next_st.bank = st.bank + 2'd1;
          next_st.state = ST_ISSUE;
        end else begin
          next_st.bank = 2'd0;
          next_st.state = ST_IDLE;
          case (st.purpose)
            P_CFG: begin
              case (st.walk[1:0])
                2'd0: begin
                  next_st.code_src = rbyte[B_SRC];
                  next_st.sram_otp_compare_enable = rbyte[B_CMP];
                end
                2'd1: next_st.ecc_mode = rbyte;
                default: begin
                  next_st.readout_unlock_bits = rbyte[1:0];
                  next_st.readout_guard = (rbyte[1:0] == 2'b00);
                end
              endcase
              next_st.walk = st.walk + 12'd1;
              next_st.eaddr = st.eaddr + 12'd1;
              next_st.state = ST_ISSUE;
              if (st.walk[1:0] == CFG_LAST) begin
                next_st.walk = 12'h0;
                next_st.eaddr = 12'h0;
                next_st.purpose = P_COPY;
                if (!next_st.code_src) begin
                  next_st.boot_done = 1'b1;
                  next_st.state = ST_IDLE;
                end
              end
            end
            P_COPY: begin
              sram_we = 1'b1;
              sram_wd = rbyte;
              next_st.walk = st.walk + 12'd1;
              next_st.eaddr = st.walk + 12'd1;
              next_st.state = ST_ISSUE;
              if (st.walk == last_addr) begin
                next_st.walk = 12'h0;
                next_st.boot_done = 1'b1;
                next_st.state = ST_IDLE;
              end
            end
            P_FETCH: begin
              next_st.fetch_data = rbyte;
              next_st.fetch_valid = 1'b1;
            end
            P_HOST: begin
              next_st.mem_data = rbyte;
              next_st.host_pend = host_set;
            end
            default: begin
              mismatch = (rbyte != sram[st.walk]);
              next_st.walk = (st.walk == last_addr) ? 12'h0 : st.walk + 12'd1;
              if (mismatch) begin
                // same path as power-on: config, recopy, restart
                next_st = RESET_VAL;
                next_st.axi = st.axi;
                next_st.aw_hold = st.aw_hold;
                next_st.w_hold = st.w_hold;
                next_st.awaddr = st.awaddr;
                next_st.wdata = st.wdata;
                next_st.wbyte = st.wbyte;
                next_st.core_restart = 1'b1;
              end
            end
          endcase
        end
      end
      default: next_st.state = ST_IDLE;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) st <= RESET_VAL;
    else st <= next_st;
  end

  // array contents are not reset; the boot copy rewrites bytes 0 to last_addr, only the lower 2 kB in mode F0
  always_ff @(posedge aclk) begin
    if (sram_we) sram[sram_wa] <= sram_wd;
  end

  // ************************************************************
  // checks
  // ************************************************************
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  a_none_passes: assert property (st.state == ST_WAIT && st.purpose == P_FETCH
    && mode_eff == MODE_NONE |=> fetch_valid && fetch_data == $past(otp_rdata))
    else $error("direct mode altered a fetched byte");
  a_parity_bank: assert property (otp_ren && st.ecc_mode == MODE_PAR && st.purpose != P_CFG
    |-> otp_addr[12] == st.bank[0])
    else $error("parity byte not read from upper half");
  a_parity_fix: assert property (st.state == ST_WAIT && st.purpose == P_FETCH && last_bank
    && mode_eff == MODE_PAR |=> fetch_data == oer_fix($past(st.acc), $past(otp_rdata)))
    else $error("parity correction not applied");
  a_quad_banks: assert property (otp_ren && st.ecc_mode == MODE_QUAD && st.purpose != P_CFG
    |-> otp_addr[12:11] == $past(st.bank))
    else $error("quad bank address wrong");
  a_quad_and: assert property (st.state == ST_WAIT && st.purpose == P_FETCH && last_bank
    && mode_eff == MODE_QUAD |=> fetch_data == ($past(st.acc) & $past(otp_rdata)))
    else $error("quad result is not the AND of banks");
  a_guard_blocks: assert property (st.readout_guard && axi_req.arvalid && st.axi.arready
    && axi_req.araddr == A_MDATA |=> axi_rsp.rdata == 32'h0 && axi_rsp.rresp == RESP_ERR)
    else $error("readout not blocked under guard");
  a_guard_at_boot: assert property (st.readout_guard != $past(st.readout_guard)
    |-> $past(st.purpose) == P_CFG || core_restart)
    else $error("guard changed outside boot");
  a_src_sram: assert property (st.state == ST_IDLE && fetch_req && !fetch_valid && st.code_src
    |=> fetch_valid && !otp_ren)
    else $error("sram fetch did not answer next cycle");
  a_mismatch_boot: assert property (mismatch |=> core_restart && !boot_done
    && st.purpose == P_CFG && st.state == ST_ISSUE)
    else $error("mismatch did not restart boot");
endmodule // oer_core

// *** inc/oer_pkg.sv ***
package oer_pkg;
  // ************************************************************
  // geometry, modes, register map
  // ************************************************************
  localparam int unsigned AW          = 8;
  localparam logic [11:0] LAST_FULL   = 12'hFFF;
  localparam logic [11:0] LAST_QUAD   = 12'h7FF;
  localparam logic [7:0]  MODE_NONE   = 8'h00;
  localparam logic [7:0]  MODE_PAR    = 8'h0F;
  localparam logic [7:0]  MODE_QUAD   = 8'hF0;
  localparam logic [11:0] CFG_BASE    = 12'hFB0;
  localparam logic [1:0]  CFG_LAST    = 2'h2;
  localparam logic [7:0]  BLANK       = 8'hFF;
  localparam logic [AW-1:0] A_CFG0    = 8'h00;
  localparam logic [AW-1:0] A_CFG1    = 8'h04;
  localparam logic [AW-1:0] A_CFG2    = 8'h08;
  localparam logic [AW-1:0] A_STATUS  = 8'h0C;
  localparam logic [AW-1:0] A_MADDR   = 8'h10;
  localparam logic [AW-1:0] A_MDATA   = 8'h14;
  localparam int unsigned B_SRC       = 0;
  localparam int unsigned B_CMP       = 1;
  localparam logic [1:0]  RESP_OK     = 2'h0;
  localparam logic [1:0]  RESP_ERR    = 2'h2;
  // single-error-correcting check matrix, one column per data bit
  localparam logic [7:0]  ECC_COL [8] = '{8'h03, 8'h05, 8'h06, 8'h09,
                                          8'h0A, 8'h0C, 8'h11, 8'h12};

  function automatic logic [7:0] oer_par(input logic [7:0] d);
    logic [7:0] p;
    p = 8'h00;
    for (int i = 0; i < 8; i++) if (d[i]) p = p ^ ECC_COL[i];
    return p;
  endfunction

  function automatic logic [7:0] oer_fix(input logic [7:0] d, input logic [7:0] p);
    logic [7:0] s;
    logic [7:0] o;
    s = p ^ oer_par(d);
    o = d;
    for (int i = 0; i < 8; i++) if (s == ECC_COL[i]) o[i] = ~d[i];
    return o;
  endfunction

  typedef enum logic [2:0] {ST_IDLE = 3'b001, ST_ISSUE = 3'b010,
                            ST_WAIT = 3'b100} oer_state_type;
  typedef enum logic [2:0] {P_CFG, P_COPY, P_FETCH, P_HOST, P_CMP} oer_purpose_type;

  typedef struct packed {
    logic          awvalid;
    logic [AW-1:0] awaddr;
    logic          wvalid;
    logic [31:0]   wdata;
    logic [3:0]    wstrb;
    logic          bready;
    logic          arvalid;
    logic [AW-1:0] araddr;
    logic          rready;
  } oer_axi_req_type;

  typedef struct packed {
    logic        awready;
    logic        wready;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        arready;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
  } oer_axi_rsp_type;
endpackage

// *** test/oer_otp_model.sv ***
`timescale 1ns/1ns
// ************************************************************
// otp array model
// ************************************************************
module oer_otp_model (
  input  wire logic        otp_ren,
  input  wire logic [12:0] otp_addr,
  output logic [7:0]       otp_rdata
);
  logic [7:0] mem [8192];
  initial begin
    foreach (mem[i]) mem[i] = 8'hFF;
  end
  // engine samples at the edge ending the strobe cycle; inverted otherwise so stale use shows
  assign otp_rdata = otp_ren ? mem[otp_addr] : ~mem[otp_addr];
endmodule // oer_otp_model

// *** test/otp_ecc_read_protect_test.sv ***
`timescale 1ns/1ns
module otp_ecc_read_protect_test import oer_pkg::*; ();
  logic            aclk;
  logic            aresetn;
  oer_axi_req_type axi_req;
  oer_axi_rsp_type axi_rsp;
  logic            fetch_req;
  logic [11:0]     fetch_addr;
  logic            fetch_valid;
  logic [7:0]      fetch_data;
  logic            otp_ren;
  logic [12:0]     otp_addr;
  logic [7:0]      otp_rdata;
  logic            core_restart;
  logic            boot_done;
  int              fail_count;
  int              checks;
  logic [31:0]     rd;
  logic [1:0]      rs;

  oer_core u_oer_core (.aclk(aclk), .aresetn(aresetn), .axi_req(axi_req), .axi_rsp(axi_rsp),
    .fetch_req(fetch_req), .fetch_addr(fetch_addr), .fetch_valid(fetch_valid),
    .fetch_data(fetch_data), .otp_ren(otp_ren), .otp_addr(otp_addr), .otp_rdata(otp_rdata),
    .core_restart(core_restart), .boot_done(boot_done));
  oer_otp_model u_oer_otp_model (.otp_ren(otp_ren), .otp_addr(otp_addr),
    .otp_rdata(otp_rdata));

  always #20 aclk = ~aclk;

  // ************************************************************
  // shared tasks
  // ************************************************************
  task automatic finish_test();
    $display("checks %0d fail_count %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (got !== exp) begin
      fail_count++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic hang(input string what);
    fail_count++;
    $display("[FAIL] %s expected done seen timeout", what);
    finish_test();
  endtask

  task automatic axi_write(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    int n;
    logic ta, tw, bv;
    @(posedge aclk);
    axi_req.awvalid <= 1'b1;
    axi_req.awaddr <= a;
    axi_req.wvalid <= 1'b1;
    axi_req.wdata <= d;
    axi_req.wstrb <= 4'hF;
    axi_req.bready <= 1'b1;
    for (n = 0; n < 100; n++) begin
      @(negedge aclk);
      ta = axi_req.awvalid && axi_rsp.awready;
      tw = axi_req.wvalid && axi_rsp.wready;
      bv = axi_rsp.bvalid;
      r = axi_rsp.bresp;
      @(posedge aclk);
      if (ta) axi_req.awvalid <= 1'b0;
      if (tw) axi_req.wvalid <= 1'b0;
      if (bv === 1'b1) break;
    end
    axi_req.bready <= 1'b0;
    if (n == 100) hang("axi write");
  endtask

  task automatic axi_read(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    int n;
    logic ta, rv;
    @(posedge aclk);
    axi_req.arvalid <= 1'b1;
    axi_req.araddr <= a;
    axi_req.rready <= 1'b1;
    for (n = 0; n < 100; n++) begin
      @(negedge aclk);
      ta = axi_req.arvalid && axi_rsp.arready;
      rv = axi_rsp.rvalid;
      d = axi_rsp.rdata;
      r = axi_rsp.rresp;
      @(posedge aclk);
      if (ta) axi_req.arvalid <= 1'b0;
      if (rv === 1'b1) break;
    end
    axi_req.rready <= 1'b0;
    if (n == 100) hang("axi read");
  endtask

  // lat 0 skips the latency figure where compare steps may delay the answer
  task automatic fetch(input logic [11:0] a, input logic [7:0] exp, input int lat);
    int n;
    @(posedge aclk);
    fetch_req <= 1'b1;
    fetch_addr <= a;
    for (n = 0; n < 40; n++) begin
      @(negedge aclk);
      if (fetch_valid === 1'b1) break;
    end
    if (n == 40) hang("fetch");
    chk("fetch data", exp, fetch_data);
    if (lat > 0) chk("fetch latency", lat, n);
    @(posedge aclk);
    fetch_req <= 1'b0;
  endtask

  task automatic wait_boot();
    int n;
    for (n = 0; n < 40000; n++) begin
      @(negedge aclk);
      if (boot_done === 1'b1) break;
    end
    if (n == 40000) hang("boot");
  endtask

  task automatic do_reset(input logic [7:0] cfg, input logic [7:0] mode, input logic [7:0] ul);
    u_oer_otp_model.mem[12'hFB0] = cfg;
    u_oer_otp_model.mem[12'hFB1] = mode;
    u_oer_otp_model.mem[12'hFB2] = ul;
    @(posedge aclk);
    aresetn <= 1'b0;
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    wait_boot();
  endtask

  function automatic logic [7:0] par(input logic [7:0] d);
    logic [7:0] col [8];
    logic [7:0] p;
    col = '{8'h03, 8'h05, 8'h06, 8'h09, 8'h0A, 8'h0C, 8'h11, 8'h12};
    p = 8'h00;
    for (int i = 0; i < 8; i++) if (d[i]) p = p ^ col[i];
    return p;
  endfunction

  // ************************************************************
  // scenarios
  // ************************************************************
  task automatic s_plain();
    do_reset(8'h00, MODE_NONE, 8'h03);
    axi_read(A_STATUS, rd, rs);
    chk("status boot", 32'h1, rd & 32'h1);
    axi_read(A_CFG1, rd, rs);
    chk("cfg1", 32'h0, rd);
    fetch(12'h123, 8'hA5, 3);
    fetch(12'h040, 8'h52, 3);
    fetch(12'h200, 8'hFF, 3);
  endtask

  task automatic s_parity();
    do_reset(8'h00, MODE_PAR, 8'h03);
    axi_read(A_CFG1, rd, rs);
    chk("cfg1 parity", {24'h0, MODE_PAR}, rd);
    fetch(12'h040, 8'h5A, 5);
    fetch(12'h200, 8'hFF, 5);
  endtask

  task automatic s_quad();
    do_reset(8'h00, MODE_QUAD, 8'h03);
    fetch(12'h010, 8'h76, 9);
  endtask

  task automatic s_lock();
    do_reset(8'h00, MODE_NONE, 8'h03);
    axi_write(A_MADDR, 32'h123, rs);
    repeat (20) @(posedge aclk);
    axi_read(A_MDATA, rd, rs);
    chk("open readout", 32'hA5, rd);
    axi_write(A_CFG2, 32'h0, rs);
    chk("cfg2 write resp", RESP_OK, rs);
    axi_read(A_STATUS, rd, rs);
    chk("guard before reset", 32'h0, rd & 32'h2);
    axi_write(A_MADDR, 32'h040, rs);
    repeat (20) @(posedge aclk);
    axi_read(A_MDATA, rd, rs);
    chk("otp read before reset", 32'h52, rd);
    do_reset(8'h00, MODE_NONE, 8'h00);
    axi_read(A_STATUS, rd, rs);
    chk("guard after reset", 32'h2, rd & 32'h2);
    axi_write(A_MADDR, 32'h123, rs);
    axi_read(A_MDATA, rd, rs);
    chk("locked resp", RESP_ERR, rs);
    chk("locked data", 32'h0, rd);
  endtask

  task automatic s_bus();
    axi_read(8'h20, rd, rs);
    chk("unmapped read resp", RESP_ERR, rs);
    chk("unmapped read data", 32'h0, rd);
    axi_write(8'h24, 32'h1, rs);
    chk("unmapped write resp", RESP_ERR, rs);
  endtask

  task automatic s_sram();
    int n;
    do_reset(8'h01, MODE_NONE, 8'h03);
    fetch(12'h123, 8'hA5, 1);
    axi_write(A_MADDR, 32'h123, rs);
    repeat (4) @(posedge aclk);
    axi_read(A_MDATA, rd, rs);
    chk("sram readout", 32'hA5, rd);
    do_reset(8'h03, MODE_NONE, 8'h03);
    u_oer_otp_model.mem[5] = 8'h00;
    for (n = 0; n < 40000; n++) begin
      @(negedge aclk);
      if (core_restart === 1'b1) break;
    end
    if (n == 40000) hang("compare restart");
    chk("restart pulse", 32'h1, core_restart);
    chk("boot cleared", 32'h0, boot_done);
    repeat (2) @(posedge aclk);
    wait_boot();
    fetch(12'h005, 8'h00, 0);
  endtask

  initial begin
    aclk = 1'b0;
    aresetn = 1'b0;
    axi_req = '0;
    fetch_req = 1'b0;
    fetch_addr = 12'h000;
    fail_count = 0;
    checks = 0;
    @(posedge aclk);
    u_oer_otp_model.mem[12'h123] = 8'hA5;
    u_oer_otp_model.mem[12'h040] = 8'h52;
    u_oer_otp_model.mem[13'h1040] = par(8'h5A);
    u_oer_otp_model.mem[12'h010] = 8'hF7;
    u_oer_otp_model.mem[12'h810] = 8'h7F;
    u_oer_otp_model.mem[13'h1810] = 8'hFE;
    s_plain();
    s_parity();
    s_quad();
    s_lock();
    s_bus();
    s_sram();
    finish_test();
  end
endmodule // otp_ecc_read_protect_test
